// ### include/pce_pkg.sv
// Package: pitch contour envelope constants, register map and types
package pce_pkg;
  // Register byte offsets
  localparam logic [7:0] PCE_OFF_TIMES = 8'h00;
  localparam logic [7:0] PCE_OFF_SHAPE = 8'h04;
  localparam logic [7:0] PCE_OFF_CTRL = 8'h08;
  localparam logic [7:0] PCE_OFF_STAT = 8'h0C;
  // Field positions in TIMES: delay, attack, decay, sustain (7 bits each in a byte)
  localparam int PCE_POS_DELAY = 0;
  localparam int PCE_POS_ATTACK = 8;
  localparam int PCE_POS_DECAY = 16;
  localparam int PCE_POS_SUSTAIN = 24;
  // Field positions in SHAPE: sustain decay, release, level, velocity mod
  localparam int PCE_POS_SDECAY = 0;
  localparam int PCE_POS_RELEASE = 8;
  localparam int PCE_POS_LEVEL = 16;
  localparam int PCE_POS_VELMOD = 24;
  // Field positions in CTRL
  localparam int PCE_POS_TRIG = 0;
  localparam int PCE_POS_TTRACK = 2;
  localparam int PCE_POS_PEDRESP = 3;
  localparam int PCE_POS_DEPTH = 8;
  localparam int PCE_POS_ROUTED = 16;
  // Reset values
  localparam logic [31:0] PCE_RST_TIMES = 32'h63000000;
  localparam logic [31:0] PCE_RST_SHAPE = 32'h00006300;
  localparam logic [31:0] PCE_RST_CTRL = 32'h00000000;
  // Parameter range
  localparam logic [6:0] PCE_MAX_PARAM = 7'h63;
  localparam logic [6:0] PCE_HOLD_PARAM = 7'h64;
  // Envelope level: 16 bits, full scale
  localparam logic [15:0] PCE_LVL_MAX = 16'hFFFF;
  // Update tick: 10 us at 200 MHz
  localparam int PCE_CLK_MHZ = 200;
  localparam int PCE_TICK_NS = 10000;
  localparam int PCE_TICK_CYC = PCE_TICK_NS * PCE_CLK_MHZ / 1000;
  // Key reference for time tracking (middle C)
  localparam logic [6:0] PCE_KEY_REF = 7'h3C;
  localparam logic [4:0] PCE_TRACK_SPAN = 5'h18;

  typedef enum logic [1:0] {
    PCE_TRIG_NORMAL,
    PCE_TRIG_FREERUN,
    PCE_TRIG_RESET,
    PCE_TRIG_RESET_FREE
  } pce_trig_e;

  typedef enum logic [2:0] {
    PCE_ST_IDLE,
    PCE_ST_DELAY,
    PCE_ST_ATTACK,
    PCE_ST_DECAY,
    PCE_ST_SUSTAIN,
    PCE_ST_RELEASE,
    PCE_ST_HOLD
  } pce_state_e;

  // Segment rate per tick from a 0..99 parameter: longer for larger values
  function automatic logic [15:0] pce_rate(input logic [6:0] p);
    logic [6:0] inv;
    logic [15:0] r;
    inv = PCE_MAX_PARAM - ((p > PCE_MAX_PARAM) ? PCE_MAX_PARAM : p);
    r = 16'h0001 << inv[6:3];
    r = r + ((r >> 3) * {13'h0000, inv[2:0]});
    return r;
  endfunction
endpackage

// ### logic/pce_pitch_contour.sv
// Pitch contour envelope generator with AHB-Lite register slave
//
// What this block does
// - Output only when depth nonzero or routed
// - Zero attack and delay: immediate maximum
// - Decay toward sustain; sustain 99 skips decay
// - Release falls from current level to zero
// - Release above 99 holds level
// - Delay postpones attack; zero starts at once
// - Delay hold waits for release, forces freerun
// - Sustain decay falls; 99 holds, 0 drops
// - Normal mode: new note does not restart
// - Normal mode: note off goes to release
// - Freerun completes whole cycle
// - Reset mode restarts on every note
// - Reset-freerun restarts and completes cycle
// - Mono legato retriggers only in reset modes
// - Key tracking scales decay, sustain decay and release times, two octaves
// - Pedal, fast start: jump to sustain decay
// - Pedal, release in attack: go release
// - Pedal, release before attack: stay zero
// - Pedal freerun stays in sustain decay; off ignores
// - Level scales output, 00 none, 99 full
// - Velocity modulation scales by velocity
`timescale 1ns/1ps
module pce_pitch_contour
  import pce_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Voice note events, same clock domain
  input wire logic NOTE_ON,
  input wire logic NOTE_OFF,
  input wire logic [6:0] NOTE_KEY,
  input wire logic [6:0] NOTE_VEL,
  input wire logic LEGATO,
  input wire logic MONO_MODE,
  // Sustain pedal pin
  input wire logic PEDAL,
  // Contour to the pitch destination
  output logic [15:0] CONTOUR_OUT
);
  logic [31:0] times_q;
  logic [31:0] shape_q;
  logic [31:0] ctrl_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [7:0] a_off;
  logic a_take;
  logic ped_s1_q;
  logic ped_s2_q;
  pce_state_e state_q;
  logic [15:0] lvl_q;
  logic [15:0] tick_q;
  logic tick;
  logic gate_q;
  logic free_q;
  logic [6:0] key_q;
  logic [6:0] vel_q;
  logic [6:0] p_delay;
  logic [6:0] p_attack;
  logic [6:0] p_decay;
  logic [6:0] p_sus;
  logic [6:0] p_sdecay;
  logic [6:0] p_rel;
  pce_trig_e trig;
  logic ttrack;
  logic pedresp;
  logic routed;
  logic [15:0] sus_lvl;
  logic retrig;
  logic free_eff;
  logic ped_held;
  logic [15:0] rate_dec;
  logic [15:0] rate_sd;
  logic [15:0] rate_rel;
  logic [15:0] dly_rate;
  logic [15:0] scaled_out;

  always_comb begin
    p_delay = times_q[PCE_POS_DELAY +: 7];
    p_attack = times_q[PCE_POS_ATTACK +: 7];
    p_decay = times_q[PCE_POS_DECAY +: 7];
    p_sus = times_q[PCE_POS_SUSTAIN +: 7];
    p_sdecay = shape_q[PCE_POS_SDECAY +: 7];
    p_rel = shape_q[PCE_POS_RELEASE +: 7];
    trig = pce_trig_e'(ctrl_q[PCE_POS_TRIG +: 2]);
    ttrack = ctrl_q[PCE_POS_TTRACK];
    pedresp = ctrl_q[PCE_POS_PEDRESP];
    routed = (ctrl_q[PCE_POS_DEPTH +: 7] != 7'h00) || ctrl_q[PCE_POS_ROUTED];
    sus_lvl = (p_sus >= PCE_MAX_PARAM) ? PCE_LVL_MAX : {p_sus, 9'h000};
    ped_held = pedresp && ped_s2_q;
    free_eff = trig[0] || (p_delay > PCE_MAX_PARAM);
    // restart only in reset modes; mono legato follows same test
    retrig = trig[1] && (!(MONO_MODE && LEGATO) || trig[1]);
    a_off = HADDR[7:0];
    a_take = HSEL && HREADY && HTRANS[1];
  end

  // key tracking: doubles or halves over 24 keys
  function automatic logic [15:0] track(input logic [15:0] r, input logic on,
                                        input logic [6:0] key);
    logic [15:0] res;
    logic [6:0] d;
    logic [31:0] prod;
    res = r;
    if (on) begin
      if (key >= PCE_KEY_REF) begin
        d = key - PCE_KEY_REF;
        d = (d > 7'(PCE_TRACK_SPAN)) ? 7'(PCE_TRACK_SPAN) : d;
        // Product kept wide so fast rates cannot wrap
        prod = 32'(r) * 32'(d);
        res = 16'(32'(r) + prod / 32'(PCE_TRACK_SPAN));
      end else begin
        d = PCE_KEY_REF - key;
        d = (d > 7'(PCE_TRACK_SPAN)) ? 7'(PCE_TRACK_SPAN) : d;
        prod = 32'(r) * 32'(d);
        res = 16'(32'(r) - prod / (32'h2 * 32'(PCE_TRACK_SPAN)));
      end
      if (res == 16'h0000) res = 16'h0001;
    end
    return res;
  endfunction

  always_comb begin
    rate_dec = track(pce_rate(p_decay), ttrack, key_q);
    rate_sd = track(pce_rate(p_sdecay), ttrack, key_q);
    rate_rel = track(pce_rate(p_rel), ttrack, key_q);
    dly_rate = pce_rate(p_delay);
  end

  // Pedal pin synchroniser
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ped_s1_q <= 1'b0;
      ped_s2_q <= 1'b0;
    end else begin
      ped_s1_q <= PEDAL;
      ped_s2_q <= ped_s1_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_q <= 16'h0000;
    end else if (tick) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end
  assign tick = (tick_q == 16'(PCE_TICK_CYC - 1));

  // Bus: address phase capture, write in data phase, zero wait
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= a_take && HWRITE;
      wr_addr_q <= a_off;
      if (a_take && !HWRITE) begin
        case (a_off)
          PCE_OFF_TIMES: rdata_q <= times_q;
          PCE_OFF_SHAPE: rdata_q <= shape_q;
          PCE_OFF_CTRL: rdata_q <= ctrl_q;
          PCE_OFF_STAT: rdata_q <= {8'h00, 5'h00, state_q, lvl_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      times_q <= PCE_RST_TIMES;
      shape_q <= PCE_RST_SHAPE;
      ctrl_q <= PCE_RST_CTRL;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        PCE_OFF_TIMES: times_q <= HWDATA & 32'h7F7F7F7F;
        PCE_OFF_SHAPE: shape_q <= HWDATA & 32'h7F7F7F7F;
        PCE_OFF_CTRL: ctrl_q <= HWDATA & 32'h00017F0F;
        default: ;
      endcase
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Note capture and gate
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      key_q <= 7'h00;
      vel_q <= 7'h00;
      gate_q <= 1'b0;
      free_q <= 1'b0;
    end else begin
      if (NOTE_ON) begin
        key_q <= NOTE_KEY;
        vel_q <= NOTE_VEL;
        gate_q <= 1'b1;
        free_q <= free_eff;
      end else if (NOTE_OFF) begin
        gate_q <= 1'b0;
      end
    end
  end

  // Envelope state machine
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= PCE_ST_IDLE;
      lvl_q <= 16'h0000;
    end else if (NOTE_ON && (retrig && !(MONO_MODE && LEGATO && !trig[1])
                 || state_q == PCE_ST_IDLE)) begin
      // restart; mono legato only in reset modes
      lvl_q <= 16'h0000;
      // zero delay goes straight to attack
      state_q <= (p_delay == 7'h00) ? PCE_ST_ATTACK : PCE_ST_DELAY;
      if (p_delay == 7'h00 && p_attack == 7'h00) begin
        lvl_q <= PCE_LVL_MAX;
        state_q <= (p_sus >= PCE_MAX_PARAM) ? PCE_ST_SUSTAIN : PCE_ST_DECAY;
      end
    end else if (NOTE_OFF && !free_q && !ped_held && state_q != PCE_ST_IDLE
                 && state_q != PCE_ST_RELEASE && state_q != PCE_ST_HOLD) begin
      // normal: release now; hold keeps level
      state_q <= (p_rel > PCE_MAX_PARAM) ? PCE_ST_HOLD : PCE_ST_RELEASE;
    end else if (NOTE_OFF && ped_held && !free_q) begin
      if (state_q == PCE_ST_DELAY) begin
        state_q <= PCE_ST_IDLE;
        lvl_q <= 16'h0000;
      end else if (state_q == PCE_ST_ATTACK) begin
        state_q <= (p_rel > PCE_MAX_PARAM) ? PCE_ST_HOLD : PCE_ST_RELEASE;
      // fast start jumps to sustain decay
      end else if (p_attack == 7'h00 && p_delay == 7'h00
                   && (p_decay == 7'h00 || p_sus >= PCE_MAX_PARAM)
                   && state_q == PCE_ST_DECAY) begin
        state_q <= PCE_ST_SUSTAIN;
        lvl_q <= sus_lvl;
      end
    end else if (tick) begin
      case (state_q)
        PCE_ST_DELAY: begin
          if (p_delay > PCE_MAX_PARAM) begin
            if (!gate_q) state_q <= PCE_ST_ATTACK;
          end else if (lvl_q >= 16'(PCE_LVL_MAX - dly_rate)) begin
            lvl_q <= 16'h0000;
            state_q <= PCE_ST_ATTACK;
          end else begin
            // Level register reused as delay timer
            lvl_q <= lvl_q + dly_rate;
          end
        end
        PCE_ST_ATTACK: begin
          // attack rate is never key tracked
          if (p_attack == 7'h00 || lvl_q >= 16'(PCE_LVL_MAX - pce_rate(p_attack))) begin
            lvl_q <= PCE_LVL_MAX;
            state_q <= (p_sus >= PCE_MAX_PARAM) ? PCE_ST_SUSTAIN : PCE_ST_DECAY;
          end else begin
            lvl_q <= lvl_q + pce_rate(p_attack);
          end
        end
        PCE_ST_DECAY: begin
          if (p_decay == 7'h00 || lvl_q <= 16'(sus_lvl + rate_dec)) begin
            lvl_q <= sus_lvl;
            state_q <= PCE_ST_SUSTAIN;
          end else begin
            lvl_q <= lvl_q - rate_dec;
          end
        end
        PCE_ST_SUSTAIN: begin
          // sustain decay; freerun ends here then releases
          if (free_q && !gate_q && !ped_held) begin
            state_q <= (p_rel > PCE_MAX_PARAM) ? PCE_ST_HOLD : PCE_ST_RELEASE;
          end else if (p_sdecay >= PCE_MAX_PARAM) begin
            lvl_q <= lvl_q;
          end else if (p_sdecay == 7'h00 || lvl_q <= rate_sd) begin
            lvl_q <= 16'h0000;
          end else begin
            lvl_q <= lvl_q - rate_sd;
          end
        end
        PCE_ST_RELEASE: begin
          if (p_rel == 7'h00 || lvl_q <= rate_rel) begin
            lvl_q <= 16'h0000;
            state_q <= PCE_ST_IDLE;
          end else begin
            lvl_q <= lvl_q - rate_rel;
          end
        end
        PCE_ST_HOLD: lvl_q <= lvl_q;
        PCE_ST_IDLE: lvl_q <= 16'h0000;
        default: state_q <= PCE_ST_IDLE;
      endcase
    end
  end

  pce_scale u_scale (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .env((state_q == PCE_ST_DELAY) ? 16'h0000 : lvl_q),
    .level(shape_q[PCE_POS_LEVEL +: 7]),
    .velmod(shape_q[PCE_POS_VELMOD +: 7]),
    .velocity(vel_q),
    .active(routed),
    .out_q(scaled_out)
  );

  assign CONTOUR_OUT = scaled_out;
endmodule // pce_pitch_contour

// ### logic/pce_scale.sv
// Output scaling by level and velocity
`timescale 1ns/1ps
module pce_scale
  import pce_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire logic [15:0] env,
  input wire logic [6:0] level,
  input wire logic [6:0] velmod,
  input wire logic [6:0] velocity,
  input wire logic active,
  // Result
  output logic [15:0] out_q
);
  logic [6:0] lvl_c;
  logic [6:0] vm_c;
  logic [13:0] vel_gain;
  logic [22:0] p1;
  logic [29:0] p2;

  always_comb begin
    lvl_c = (level > PCE_MAX_PARAM) ? PCE_MAX_PARAM : level;
    vm_c = (velmod > PCE_MAX_PARAM) ? PCE_MAX_PARAM : velmod;
    // Gain = 127*99 - vm*(127-vel); velmod 0 gives the top gain 12573 at any velocity
    vel_gain = 14'(14'd12573 - vm_c * (7'h7F - velocity));
    p1 = 23'(env * lvl_c);
    p2 = 30'(p1[22:7] * vel_gain);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 16'h0000;
    end else if (!active || lvl_c == 7'h00) begin
      // Level 00 or unrouted gives nothing
      out_q <= 16'h0000;
    end else begin
      out_q <= p2[29:14];
    end
  end
endmodule // pce_scale

// ### tb/pce_pitch_contour_asserts.sv
// Port checker for the pitch contour block, bound to its top
`timescale 1ns/1ps
module pce_pitch_contour_asserts
  import pce_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Voice side
  input wire logic NOTE_ON,
  input wire logic [15:0] CONTOUR_OUT
);
  // Output may lag a setting change by one update tick
  localparam logic [11:0] SETTLE = 12'h834;
  logic wr_q, rd_q;
  logic [7:0] adr_q;
  logic [31:0] times_q, shape_q, ctrl_q, msk, exp_rd;
  logic [11:0] quiet_q;
  wire take = HSEL & HREADY & HTRANS[1];
  wire wdat = wr_q & HREADY;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else if (HREADY) begin
      wr_q <= take & HWRITE;
      rd_q <= take & ~HWRITE;
      adr_q <= HADDR[7:0];
    end
  end
  // Shadow of the writable registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      times_q <= PCE_RST_TIMES;
      shape_q <= PCE_RST_SHAPE;
      ctrl_q <= PCE_RST_CTRL;
    end else if (wdat) begin
      if (adr_q == PCE_OFF_TIMES) times_q <= HWDATA;
      if (adr_q == PCE_OFF_SHAPE) shape_q <= HWDATA;
      if (adr_q == PCE_OFF_CTRL) ctrl_q <= HWDATA;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      quiet_q <= 12'h000;
    end else if (wdat && (adr_q == PCE_OFF_SHAPE || adr_q == PCE_OFF_CTRL)) begin
      quiet_q <= 12'h000;
    end else if (quiet_q != SETTLE) begin
      quiet_q <= quiet_q + 12'h001;
    end
  end
  always_comb begin
    msk = (adr_q == PCE_OFF_CTRL) ? 32'h00017F0F : 32'h7F7F7F7F;
    exp_rd = (adr_q == PCE_OFF_TIMES) ? times_q : (adr_q == PCE_OFF_SHAPE) ? shape_q : ctrl_q;
  end
  property p_ready;
    HREADYOUT == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("bus slave stalled");
  property p_okay;
    HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_hold;
    !rd_q |-> $stable(HRDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap;
    rd_q && adr_q > PCE_OFF_STAT |-> HRDATA == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_readback;
    rd_q && adr_q < PCE_OFF_STAT |-> (HRDATA & msk) == (exp_rd & msk);
  endproperty
  a_readback: assert property (p_readback) else $error("register readback wrong");
  property p_state;
    rd_q && adr_q == PCE_OFF_STAT |-> HRDATA[18:16] <= 3'h6;
  endproperty
  a_state: assert property (p_state) else $error("status state out of range");
  property p_depth;
    quiet_q == SETTLE && ctrl_q[14:8] == 7'h00 && !ctrl_q[16] |-> CONTOUR_OUT == 16'h0000;
  endproperty
  a_depth: assert property (p_depth) else $error("output without depth or route");
  property p_level;
    quiet_q == SETTLE && shape_q[22:16] == 7'h00 |-> CONTOUR_OUT == 16'h0000;
  endproperty
  a_level: assert property (p_level) else $error("output with level zero");
  c_stat: cover property (rd_q && adr_q == PCE_OFF_STAT);
  c_out: cover property (CONTOUR_OUT != 16'h0000);
  c_note: cover property (NOTE_ON);
endmodule // pce_pitch_contour_asserts

bind pce_pitch_contour pce_pitch_contour_asserts u_chk (
  .CORE_CLK(CORE_CLK),
  .RST_N(RST_N),
  .HSEL(HSEL),
  .HADDR(HADDR),
  .HTRANS(HTRANS),
  .HWRITE(HWRITE),
  .HWDATA(HWDATA),
  .HREADY(HREADY),
  .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .NOTE_ON(NOTE_ON),
  .CONTOUR_OUT(CONTOUR_OUT)
);

// ### tb/pce_pitch_contour_tb.sv
// Self-checking bench for the pitch contour block
`timescale 1ns/1ps
module pce_pitch_contour_tb
  import pce_pkg::*;
;
  localparam int TK = PCE_TICK_CYC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [2:0] hsize = 3'h2;
  wire [31:0] hrdata;
  wire hready, hresp, non, noff, leg, mono, ped;
  wire [6:0] nkey, nvel;
  wire [15:0] cout;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] r, l0;
  logic [31:0] rv [3] = '{PCE_RST_TIMES, PCE_RST_SHAPE, PCE_RST_CTRL};
  logic [31:0] tt [8] = '{32'h63006300, 32'h63006300, 32'h63006300, 32'h63006300,
    32'h63006300, 32'h63006363, 32'h63006364, 32'h63006300};
  logic [31:0] tc [8] = '{32'h100, 32'h101, 32'h102, 32'h103, 32'h109, 32'h10A, 32'h100,
    32'h10A};
  // Held delay only moves on at the next update tick
  logic [2:0] ts [8] = '{PCE_ST_RELEASE, PCE_ST_ATTACK, PCE_ST_RELEASE, PCE_ST_ATTACK,
    PCE_ST_ATTACK, PCE_ST_IDLE, PCE_ST_DELAY, PCE_ST_RELEASE};
  always #2.5 clk = ~clk;
  pce_voice_src src (.clk(clk), .note_on(non), .note_off(noff), .note_key(nkey),
    .note_vel(nvel), .legato(leg), .mono_mode(mono), .pedal(ped));
  pce_pitch_contour uut (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .NOTE_ON(non), .NOTE_OFF(noff),
    .NOTE_KEY(nkey), .NOTE_VEL(nvel), .LEGATO(leg), .MONO_MODE(mono), .PEDAL(ped),
    .CONTOUR_OUT(cout));
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Single word transfer; read data lands in r
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_st(input logic [2:0] s);
    int i;
    i = 0;
    do begin
      xfer(1'b0, PCE_OFF_STAT, 32'h0);
      i++;
    end while (r[18:16] !== s && i < 2000);
    chk("state", {29'h0, r[18:16]}, {29'h0, s});
  endtask
  // Fresh reset between scenarios so each starts idle
  task automatic cfg(input logic [31:0] t, input logic [31:0] s, input logic [31:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b1, PCE_OFF_TIMES, t);
    xfer(1'b1, PCE_OFF_SHAPE, s);
    xfer(1'b1, PCE_OFF_CTRL, c);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", r, rv[i]);
    end
    xfer(1'b1, PCE_OFF_STAT, 32'hFFFFFFFF);
    xfer(1'b0, PCE_OFF_STAT, 32'h0);
    chk("status", r, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped", r, 32'h0);
    cfg(32'h63000000, 32'h00636463, 32'h00000100);
    src.play(7'h3C, 7'h64);
    wait_st(PCE_ST_SUSTAIN);
    chk("peak", {16'h0, r[15:0]}, {16'h0, PCE_LVL_MAX});
    chk("out on", {31'h0, cout != 16'h0}, 32'h1);
    xfer(1'b1, PCE_OFF_SHAPE, 32'h00006463);
    repeat (TK + 10) @(posedge clk);
    chk("level off", {16'h0, cout}, 32'h0);
    xfer(1'b1, PCE_OFF_SHAPE, 32'h00636463);
    xfer(1'b1, PCE_OFF_CTRL, 32'h00010000);
    repeat (TK + 10) @(posedge clk);
    chk("routed", {31'h0, cout != 16'h0}, 32'h1);
    xfer(1'b1, PCE_OFF_CTRL, 32'h0);
    repeat (TK + 10) @(posedge clk);
    chk("unrouted", {16'h0, cout}, 32'h0);
    src.lift();
    repeat (2 * TK) @(posedge clk);
    xfer(1'b0, PCE_OFF_STAT, 32'h0);
    chk("hold", {13'h0, r[18:0]}, {13'h0, PCE_ST_HOLD, PCE_LVL_MAX});
    cfg(32'h63000000, 32'h00630000, 32'h00000100);
    src.play(7'h3C, 7'h64);
    repeat (3 * TK) @(posedge clk);
    xfer(1'b0, PCE_OFF_STAT, 32'h0);
    chk("sustain decay", {16'h0, r[15:0]}, 32'h0);
    // Second note as mono legato; only reset modes start again
    for (int t = 0; t < 4; t++) begin
      cfg(32'h63006300, 32'h00636363, 32'h00000100 | t);
      src.play(7'h3C, 7'h64);
      repeat (3 * TK + 50) @(posedge clk);
      xfer(1'b0, PCE_OFF_STAT, 32'h0);
      l0 = r;
      src.mono_mode <= 1'b1;
      src.legato <= 1'b1;
      src.play(7'h3E, 7'h64);
      repeat (TK) @(posedge clk);
      xfer(1'b0, PCE_OFF_STAT, 32'h0);
      chk("restart", {31'h0, r[15:0] < l0[15:0]}, {31'h0, t[1]});
      src.mono_mode <= 1'b0;
      src.legato <= 1'b0;
    end
    // Pedal held throughout; only rows with pedal response honour it
    for (int i = 0; i < 8; i++) begin
      cfg(tt[i], 32'h00636363, tc[i]);
      src.pedal <= 1'b1;
      src.play(7'h3C, 7'h64);
      repeat (40) @(posedge clk);
      src.lift();
      repeat (10) @(posedge clk);
      xfer(1'b0, PCE_OFF_STAT, 32'h0);
      chk("after lift", {29'h0, r[18:16]}, {29'h0, ts[i]});
      if (i == 6) begin
        repeat (TK) @(posedge clk);
        xfer(1'b0, PCE_OFF_STAT, 32'h0);
        chk("hold delay", {29'h0, r[18:16]}, {29'h0, PCE_ST_ATTACK});
      end
      src.pedal <= 1'b0;
    end
    // Key tracking: two octaves up doubles the first decay step
    for (int k = 0; k < 2; k++) begin
      cfg(32'h00400000, 32'h00636363, 32'h00000104);
      src.play(k ? 7'h54 : 7'h3C, 7'h64);
      repeat (TK + 10) @(posedge clk);
      xfer(1'b0, PCE_OFF_STAT, 32'h0);
      if (k == 0) l0 = 32'h0000FFFF - {16'h0, r[15:0]};
    end
    chk("track", 32'h0000FFFF - {16'h0, r[15:0]}, 2 * l0);
    // Full velocity modulation: soft note gives less than a hard one
    for (int k = 0; k < 2; k++) begin
      cfg(32'h63000000, 32'h63636463, 32'h00000100);
      src.play(7'h3C, k ? 7'h7F : 7'h10);
      repeat (5) @(posedge clk);
      if (k == 0) l0 = {16'h0, cout};
    end
    chk("velocity", {31'h0, l0[15:0] < cout}, 32'h1);
    give_verdict();
  end
endmodule // pce_pitch_contour_tb

// ### tb/pce_voice_src.sv
// Voice event source standing in for the note and pedal side
`timescale 1ns/1ps
module pce_voice_src (
  // Clock
  input wire logic clk,
  // Note events
  output logic note_on,
  output logic note_off,
  output logic [6:0] note_key,
  output logic [6:0] note_vel,
  output logic legato,
  output logic mono_mode,
  // Pedal, high while held
  output logic pedal
);
  initial begin
    note_on = 1'b0;
    note_off = 1'b0;
    note_key = 7'h00;
    note_vel = 7'h00;
    legato = 1'b0;
    mono_mode = 1'b0;
    pedal = 1'b0;
  end
  // Key and velocity mean nothing off the strobe, so scramble them
  task automatic play(input logic [6:0] k, input logic [6:0] v);
    @(posedge clk);
    note_on <= 1'b1;
    note_key <= k;
    note_vel <= v;
    @(posedge clk);
    note_on <= 1'b0;
    note_key <= ~k;
    note_vel <= ~v;
  endtask
  task automatic lift();
    @(posedge clk);
    note_off <= 1'b1;
    @(posedge clk);
    note_off <= 1'b0;
  endtask
endmodule // pce_voice_src
